// ==== inc/dsi_resp_defs.svh ====
// Constants of the DSI response and error-report block
`ifndef DSI_RESP_DEFS_SVH
`define DSI_RESP_DEFS_SVH
// ==========================================
// Data types, virtual channel and command codes
`define DT_ACK_ERR 6'h02
`define DT_RD_LONG 6'h1c
`define DT_RD_ONE  6'h21
`define DT_RD_TWO  6'h22
`define DT_WR_NONE 6'h05
`define DT_WR_ONE  6'h15
`define DT_WR_LONG 6'h39
`define DT_RD_REQ  6'h06
`define DT_MAX_RET 6'h37
`define DT_NULL    6'h09
`define DT_EOT     6'h08
`define VC_OWN     2'h0
`define CMD_ERR_CNT  8'h05
`define CMD_SIG_MODE 8'h0e
// ==========================================
// Header ECC masks and checksum
`define ECC_M0 24'hf12cb7
`define ECC_M1 24'hf2555b
`define ECC_M2 24'h749a6d
`define ECC_M3 24'hb8e38e
`define ECC_M4 24'hdf03f0
`define ECC_M5 24'heffc00
`define CRC_INIT 16'hffff
`define CRC_POLY 16'h8408
// ==========================================
// Registers
`define REG_CTRL 4'h0
`define REG_LEN  4'h1
`define REG_BUF  4'h2
`define REG_STAT 4'h3
`define REG_ERRS 4'h4
`define REG_RCMD 4'h5
`define SIG_BASE_RST 8'h00
`define MAX_RET_RST  16'h0001
`define RESP_LEN_RST 8'h01
`endif

// ==== inc/dsi_resp_pkg.sv ====
// Types and packet functions of the DSI response block
`default_nettype none
`include "dsi_resp_defs.svh"
package dsi_resp_pkg;
	typedef enum logic [2:0] {LS_STOP = 3'b000, LS_LOW_POWER_TRANSFER = 3'b001, LS_ULPS = 3'b010, LS_RAR = 3'b011,
		LS_TEE = 3'b100, LS_ACK = 3'b101, LS_BTA = 3'b110, LS_HS = 3'b111} link_state_e;
	typedef enum logic [1:0] {RX_HDR = 2'b00, RX_PAY = 2'b01, RX_CRC = 2'b10} rx_state_e;
	typedef enum logic [2:0] {T_IDLE = 3'b000, T_STOP1 = 3'b001, T_SEND = 3'b010, T_ACK = 3'b011,
		T_STOP2 = 3'b100, T_BTA = 3'b101} tx_state_e;
	typedef enum logic [1:0] {PK_ERR = 2'b00, PK_ONE = 2'b01, PK_TWO = 2'b10, PK_LONG = 2'b11} pkt_kind_e;

	function automatic logic [7:0] hdr_ecc(input logic [23:0] d);
		hdr_ecc = {2'b00, ^(d & `ECC_M5), ^(d & `ECC_M4), ^(d & `ECC_M3), ^(d & `ECC_M2), ^(d & `ECC_M1),
			^(d & `ECC_M0)};
	endfunction : hdr_ecc

	// Returns {multi, corrected, repaired header}
	function automatic logic [25:0] ecc_check(input logic [31:0] h);
		logic [7:0]  syn;
		logic [23:0] fix;
		logic        hit;
		integer      i;
		syn = h[31:24] ^ hdr_ecc(h[23:0]);
		fix = h[23:0];
		hit = ((syn & (syn - 8'h1)) == 8'h00);
		for (i = 0; i < 24; i++)
		begin
			if (syn == hdr_ecc(24'h1 << i))
			begin
				fix[i] = ~fix[i];
				hit = 1'b1;
			end
		end
		ecc_check = {(syn != 8'h00) && !hit, (syn != 8'h00) && hit, fix};
	endfunction : ecc_check

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		integer      i;
		r = c;
		for (i = 0; i < 8; i++)
			r = (r[0] ^ b[i]) ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
		crc_byte = r;
	endfunction : crc_byte

	function automatic logic is_long(input logic [5:0] dt);
		is_long = (dt == `DT_WR_LONG) || (dt == `DT_NULL);
	endfunction : is_long

	function automatic logic known_dt(input logic [5:0] dt);
		known_dt = is_long(dt) || (dt == `DT_WR_NONE) || (dt == `DT_WR_ONE) || (dt == `DT_RD_REQ)
			|| (dt == `DT_MAX_RET) || (dt == `DT_EOT);
	endfunction : known_dt
endpackage : dsi_resp_pkg
`default_nettype wire

// ==== rtl/dsi_resp_top.sv ====
// DSI packet checker, error tracker and turnaround responder
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "dsi_resp_defs.svh"
module dsi_resp_top
	import dsi_resp_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        link_clk_i,
	input  wire logic [7:0]  rx_byte_i,
	input  wire logic        rx_act_i,
	input  wire logic        rx_hs_i,
	input  wire logic        ulps_i,
	input  wire logic        rar_i,
	input  wire logic        bta_i,
	input  wire logic [7:0]  phy_err_i,
	input  wire logic        tx_ready_i,
	output logic      [7:0]  tx_byte_o,
	output logic             tx_valid_o,
	output logic             lane_oe_n_o,
	output link_state_e      link_state_o,
	output logic             cmd_valid_o,
	output logic      [5:0]  cmd_dt_o,
	output logic      [7:0]  cmd_d0_o,
	output logic      [7:0]  cmd_d1_o,
	output logic             rd_req_o,
	input  wire logic [3:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o
);
	// ==========================================
	// Pin synchronisation
	logic [21:0] sv;
	logic        lrise;
	logic        s_act;
	logic        s_hs;
	logic        s_ulps;
	logic        s_rar;
	logic        s_bta;
	logic [7:0]  s_perr;
	logic [7:0]  sb;

	link_sync #(.W(22)) u_sync (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.d_i    ({link_clk_i, rx_act_i, rx_hs_i, ulps_i, rar_i, bta_i, phy_err_i, rx_byte_i}),
		.q_o    (sv),
		.rise_o (lrise)
	);
	assign s_act  = sv[20];
	assign s_hs   = sv[19];
	assign s_ulps = sv[18];
	assign s_rar  = sv[17];
	assign s_bta  = sv[16];
	assign s_perr = sv[15:8];
	assign sb     = sv[7:0];

	// ==========================================
	// Receive parser
	rx_state_e   rx_st;
	logic [15:0] cnt;
	logic [15:0] wc;
	logic [31:0] hdr;
	logic [23:0] h_fix;
	logic        h_corr;
	logic        h_multi;
	logic [15:0] crc_run;
	logic [7:0]  crc_lo;
	logic        act_d;
	logic        fin;
	logic        fin_crc;
	logic        fin_proto;
	logic [7:0]  perr_acc;
	logic        take;
	logic [31:0] hw;
	logic [25:0] chk;
	logic [13:0] err_vec;
	logic        bad;
	logic        ecc_crc;

	assign take = lrise & s_act;
	assign hw   = {sb, hdr[31:8]};
	assign chk  = ecc_check(hw);

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rx_st     <= RX_HDR;
			cnt       <= 16'h0000;
			wc        <= 16'h0000;
			hdr       <= 32'h0;
			h_fix     <= 24'h0;
			h_corr    <= 1'b0;
			h_multi   <= 1'b0;
			crc_run   <= `CRC_INIT;
			crc_lo    <= 8'h00;
			act_d     <= 1'b0;
			fin       <= 1'b0;
			fin_crc   <= 1'b0;
			fin_proto <= 1'b0;
		end
		else
		begin
			fin   <= 1'b0;
			act_d <= s_act;
			if (act_d && !s_act && (rx_st != RX_HDR || cnt != 16'h0000))
			begin
				// Burst ended inside a packet
				fin       <= 1'b1;
				fin_proto <= 1'b1;
				fin_crc   <= 1'b0;
				h_corr    <= 1'b0;
				h_multi   <= 1'b0;
				h_fix     <= 24'h0;
				rx_st     <= RX_HDR;
				cnt       <= 16'h0000;
			end
			else if (take)
			begin
				cnt <= cnt + 16'h0001;
				unique case (rx_st)
					RX_HDR:
					begin
						hdr <= hw;
						if (cnt == 16'h0003)
						begin
							h_fix     <= chk[23:0];
							h_corr    <= chk[24];
							h_multi   <= chk[25];
							wc        <= chk[23:8];
							crc_run   <= `CRC_INIT;
							fin_crc   <= 1'b0;
							fin_proto <= 1'b0;
							cnt       <= 16'h0000;
							// Word count is not trusted after a multi-bit error
							if (!chk[25] && is_long(chk[5:0]))
								rx_st <= (chk[23:8] == 16'h0000) ? RX_CRC : RX_PAY;
							else
								fin <= 1'b1;
						end
					end
					RX_PAY:
					begin
						crc_run <= crc_byte(crc_run, sb);
						if (cnt == wc - 16'h0001)
						begin
							rx_st <= RX_CRC;
							cnt   <= 16'h0000;
						end
					end
					RX_CRC:
					begin
						crc_lo <= sb;
						if (cnt == 16'h0001)
						begin
							fin     <= 1'b1;
							fin_crc <= ({sb, crc_lo} != crc_run);
							rx_st   <= RX_HDR;
							cnt     <= 16'h0000;
						end
					end
					default: rx_st <= RX_HDR;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			perr_acc <= 8'h00;
		else if (fin)
			perr_acc <= 8'h00;
		else if (take)
			perr_acc <= perr_acc | s_perr;
	end

	// Bit 8 alone still lets the command run
	assign err_vec = {fin_proto, h_fix[7:6] != `VC_OWN, !known_dt(h_fix[5:0]), fin_crc, h_multi, h_corr,
		perr_acc};
	assign bad     = |{err_vec[13:9], err_vec[7:0]};
	assign ecc_crc = |err_vec[10:8];

	// ==========================================
	// Error flag, counter and report accumulator
	logic        flag;
	logic [7:0]  ecnt;
	logic [13:0] err_accum;
	logic        clr_cnt;
	logic        accum_clr;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			flag      <= 1'b0;
			ecnt      <= 8'h00;
			err_accum <= 14'h0;
		end
		else
		begin
			flag <= (flag & ~clr_cnt) | (fin & (|err_vec));
			if (fin && ecc_crc)
				ecnt <= (clr_cnt ? 8'h00 : ecnt) + ((ecnt == 8'hff && !clr_cnt) ? 8'h00 : 8'h01);
			else if (clr_cnt)
				ecnt <= 8'h00;
			err_accum <= (accum_clr ? 14'h0 : err_accum) | (fin ? err_vec : 14'h0);
		end
	end

	// ==========================================
	// Command dispatch
	logic        rd_pend;
	logic [7:0]  rd_cmd;
	logic        rd_corr;
	logic [15:0] max_ret;
	logic        rd_done;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rd_pend     <= 1'b0;
			rd_cmd      <= 8'h00;
			rd_corr     <= 1'b0;
			max_ret     <= `MAX_RET_RST;
			cmd_valid_o <= 1'b0;
			cmd_dt_o    <= 6'h00;
			cmd_d0_o    <= 8'h00;
			cmd_d1_o    <= 8'h00;
			rd_req_o    <= 1'b0;
		end
		else
		begin
			cmd_valid_o <= 1'b0;
			rd_req_o    <= 1'b0;
			if (rd_done)
				rd_pend <= 1'b0;
			if (fin && !bad)
			begin
				if (h_fix[5:0] == `DT_RD_REQ)
				begin
					rd_pend  <= 1'b1;
					rd_cmd   <= h_fix[15:8];
					rd_corr  <= h_corr;
					rd_req_o <= (h_fix[15:8] != `CMD_ERR_CNT) && (h_fix[15:8] != `CMD_SIG_MODE);
				end
				else if (h_fix[5:0] == `DT_MAX_RET)
					max_ret <= h_fix[23:8];
				else if (h_fix[5:0] == `DT_WR_NONE || h_fix[5:0] == `DT_WR_ONE || h_fix[5:0] == `DT_WR_LONG)
				begin
					cmd_valid_o <= 1'b1;
					cmd_dt_o    <= h_fix[5:0];
					cmd_d0_o    <= h_fix[15:8];
					cmd_d1_o    <= h_fix[23:16];
				end
			end
		end
	end

	// ==========================================
	// Register port
	logic [7:0] sig_base;
	logic [7:0] resp_len;
	logic [7:0] wptr;
	logic [7:0] buf_rd;
	logic [7:0] buf_ra;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sig_base <= `SIG_BASE_RST;
			resp_len <= `RESP_LEN_RST;
			wptr     <= 8'h00;
			rdata_o  <= 16'h0000;
		end
		else
		begin
			if (wr_i && addr_i == `REG_CTRL)
				sig_base <= wdata_i[7:0];
			if (wr_i && addr_i == `REG_LEN)
			begin
				resp_len <= wdata_i[7:0];
				wptr     <= 8'h00;
			end
			if (wr_i && addr_i == `REG_BUF)
				wptr <= wptr + 8'h01;
			rdata_o <= 16'h0000;
			if (rd_i)
			begin
				unique case (addr_i)
					`REG_CTRL: rdata_o <= {8'h00, sig_base};
					`REG_LEN:  rdata_o <= {8'h00, resp_len};
					`REG_STAT: rdata_o <= {6'h00, rd_pend, flag, ecnt};
					`REG_ERRS: rdata_o <= {2'b00, err_accum};
					`REG_RCMD: rdata_o <= {max_ret[7:0], rd_cmd};
					default:   rdata_o <= 16'h0000;
				endcase
			end
		end
	end

	resp_buf u_buf (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.we_i    (wr_i && addr_i == `REG_BUF),
		.waddr_i (wptr),
		.wdata_i (wdata_i[7:0]),
		.raddr_i (buf_ra),
		.rdata_o (buf_rd)
	);

	// ==========================================
	// Turnaround responder
	tx_state_e tx_st;
	pkt_kind_e pkind;
	logic [8:0]  idx;
	logic        gap;
	logic [7:0]  hd0;
	logic [7:0]  hd1;
	logic [15:0] tcrc;
	logic [7:0]  len;
	logic [7:0]  ival;
	logic        err_after;
	logic        bta_d;
	logic        internal;
	logic [7:0]  lim;
	logic [7:0]  gen;
	logic [7:0]  d0v;
	logic [7:0]  d1v;
	logic        last;
	logic        in_pay;

	function automatic logic [5:0] dt_of(input pkt_kind_e k);
		unique case (k)
			PK_ERR:  dt_of = `DT_ACK_ERR;
			PK_ONE:  dt_of = `DT_RD_ONE;
			PK_TWO:  dt_of = `DT_RD_TWO;
			PK_LONG: dt_of = `DT_RD_LONG;
		endcase
	endfunction : dt_of

	assign internal = (rd_cmd == `CMD_ERR_CNT) || (rd_cmd == `CMD_SIG_MODE);
	assign lim      = ({8'h00, resp_len} > max_ret) ? max_ret[7:0] : resp_len;
	assign buf_ra   = (pkind == PK_LONG) ? 8'(idx - 9'h004) : 8'(idx - 9'h001);
	assign in_pay   = (pkind == PK_LONG) && (idx >= 9'h004) && (idx < 9'h004 + {1'b0, len});
	assign last     = (pkind == PK_LONG) ? (idx == 9'h005 + {1'b0, len}) : (idx == 9'h003);

	always_comb
	begin
		unique case (pkind)
			PK_ERR:  d0v = err_accum[7:0];
			PK_ONE:  d0v = internal ? ival : buf_rd;
			PK_TWO:  d0v = buf_rd;
			PK_LONG: d0v = len;
		endcase
		unique case (pkind)
			PK_ERR:  d1v = {2'b00, err_accum[13:8]};
			PK_TWO:  d1v = buf_rd;
			default: d1v = 8'h00;
		endcase
		gen = tcrc[15:8];
		if (idx == 9'h000)
			gen = {`VC_OWN, dt_of(pkind)};
		else if (idx == 9'h001)
			gen = d0v;
		else if (idx == 9'h002)
			gen = d1v;
		else if (idx == 9'h003)
			gen = hdr_ecc({hd1, hd0, `VC_OWN, dt_of(pkind)});
		else if (in_pay)
			gen = buf_rd;
		else if (idx == 9'h004 + {1'b0, len})
			gen = tcrc[7:0];
	end

	// Each byte waits a cycle so the memory read settles
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			tx_st       <= T_IDLE;
			pkind       <= PK_ERR;
			idx         <= 9'h000;
			gap         <= 1'b0;
			hd0         <= 8'h00;
			hd1         <= 8'h00;
			tcrc        <= `CRC_INIT;
			len         <= 8'h00;
			ival        <= 8'h00;
			err_after   <= 1'b0;
			bta_d       <= 1'b0;
			tx_byte_o   <= 8'h00;
			tx_valid_o  <= 1'b0;
			lane_oe_n_o <= 1'b1;
			rd_done     <= 1'b0;
			clr_cnt     <= 1'b0;
			accum_clr   <= 1'b0;
		end
		else
		begin
			bta_d     <= s_bta;
			rd_done   <= 1'b0;
			clr_cnt   <= 1'b0;
			accum_clr <= 1'b0;
			unique case (tx_st)
				T_IDLE:
					if (s_bta && !bta_d && rx_st == RX_HDR && cnt == 16'h0000)
					begin
						tx_st       <= T_STOP1;
						lane_oe_n_o <= 1'b0;
					end
				T_STOP1:
				begin
					idx       <= 9'h000;
					gap       <= 1'b1;
					tcrc      <= `CRC_INIT;
					len       <= lim;
					ival      <= (rd_cmd == `CMD_ERR_CNT) ? ecnt : {sig_base[7:1], flag};
					err_after <= rd_corr;
					tx_st     <= T_SEND;
					if (rd_pend && (internal || lim <= 8'h01))
						pkind <= PK_ONE;
					else if (rd_pend && lim == 8'h02)
						pkind <= PK_TWO;
					else if (rd_pend)
						pkind <= PK_LONG;
					else if (err_accum != 14'h0)
						pkind <= PK_ERR;
					else
						tx_st <= T_ACK;
				end
				T_SEND:
					if (tx_valid_o)
					begin
						if (tx_ready_i)
						begin
							tx_valid_o <= 1'b0;
							gap        <= 1'b1;
							idx        <= idx + 9'h001;
							if (idx == 9'h001)
								hd0 <= tx_byte_o;
							if (idx == 9'h002)
								hd1 <= tx_byte_o;
							if (in_pay)
								tcrc <= crc_byte(tcrc, tx_byte_o);
							if (last)
							begin
								idx  <= 9'h000;
								tcrc <= `CRC_INIT;
								if (pkind != PK_ERR)
								begin
									rd_done <= 1'b1;
									clr_cnt <= (rd_cmd == `CMD_ERR_CNT);
								end
								if (pkind != PK_ERR && err_after)
									pkind <= PK_ERR;
								else
									tx_st <= T_STOP2;
							end
						end
					end
					else if (gap)
						gap <= 1'b0;
					else
					begin
						tx_byte_o  <= gen;
						tx_valid_o <= 1'b1;
					end
				T_ACK:   tx_st <= T_STOP2;
				T_STOP2: tx_st <= T_BTA;
				T_BTA:
				begin
					tx_st       <= T_IDLE;
					lane_oe_n_o <= 1'b1;
					accum_clr   <= 1'b1;
				end
				default: tx_st <= T_IDLE;
			endcase
		end
	end

	// ==========================================
	// Link state indication
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			link_state_o <= LS_STOP;
		else if (tx_st == T_ACK)
			link_state_o <= LS_ACK;
		else if (tx_st == T_BTA || (tx_st == T_IDLE && s_bta))
			link_state_o <= LS_BTA;
		else if (tx_st == T_SEND)
			link_state_o <= LS_LOW_POWER_TRANSFER;
		else if (tx_st != T_IDLE)
			link_state_o <= LS_STOP;
		else if (s_rar)
			link_state_o <= LS_RAR;
		else if (s_ulps)
			link_state_o <= LS_ULPS;
		else if (s_act)
			link_state_o <= s_hs ? LS_HS : LS_LOW_POWER_TRANSFER;
		else
			link_state_o <= LS_STOP;
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	property p_vc;
		tx_st == T_SEND && tx_valid_o && idx == 9'h000 |-> tx_byte_o[7:6] == `VC_OWN;
	endproperty
	a_vc: assert property (p_vc) else $error("bad channel");
	property p_err_dt;
		tx_valid_o && idx == 9'h000 && pkind == PK_ERR |-> tx_byte_o[5:0] == `DT_ACK_ERR;
	endproperty
	a_err_dt: assert property (p_err_dt) else $error("bad report type");
	property p_one;
		tx_valid_o && pkind == PK_ONE && idx == 9'h002 |-> tx_byte_o == 8'h00;
	endproperty
	a_one: assert property (p_one) else $error("data 1 not zero");
	property p_two_dt;
		tx_valid_o && idx == 9'h000 && pkind == PK_TWO |-> tx_byte_o[5:0] == `DT_RD_TWO;
	endproperty
	a_two_dt: assert property (p_two_dt) else $error("bad two-byte type");
	property p_long_dt;
		tx_valid_o && idx == 9'h000 && pkind == PK_LONG |-> tx_byte_o[5:0] == `DT_RD_LONG;
	endproperty
	a_long_dt: assert property (p_long_dt) else $error("bad long type");
	property p_flag;
		fin && (|err_vec) |=> flag;
	endproperty
	a_flag: assert property (p_flag) else $error("flag not set");
	property p_cnt;
		fin && ecc_crc && !clr_cnt && ecnt != 8'hff |=> ecnt == $past(ecnt) + 8'h01;
	endproperty
	a_cnt: assert property (p_cnt) else $error("counter missed");
	property p_clr;
		clr_cnt && !fin |=> ecnt == 8'h00 && !flag;
	endproperty
	a_clr: assert property (p_clr) else $error("clear on read failed");
	property p_drop;
		fin && bad |=> !cmd_valid_o && !rd_req_o;
	endproperty
	a_drop: assert property (p_drop) else $error("bad packet executed");
	property p_accum;
		fin |=> (err_accum & $past(err_vec)) == $past(err_vec);
	endproperty
	a_accum: assert property (p_accum) else $error("error lost");
	property p_oe;
		tx_st == T_SEND |-> !lane_oe_n_o;
	endproperty
	a_oe: assert property (p_oe) else $error("lane not driven");
endmodule : dsi_resp_top
`default_nettype wire

// ==== rtl/link_sync.sv ====
// Two-flop synchroniser for the lane pins with link clock edge detect
`timescale 1ns/10ps
`default_nettype none
module link_sync #(
	parameter int W = 22
) (
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o,
	output logic              rise_o
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic         clk_d;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			s1 <= '0;
			s2 <= '0;
		end
		else
		begin
			s1 <= d_i;
			s2 <= s1;
		end
	end

	// Edge detect looks at the second stage only
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			clk_d <= 1'b0;
		else
			clk_d <= s2[W-1];
	end

	assign q_o    = s2;
	assign rise_o = s2[W-1] & ~clk_d;
endmodule : link_sync
`default_nettype wire

// ==== rtl/resp_buf.sv ====
// Read-result byte memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module resp_buf (
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic       we_i,
	input  wire logic [7:0] waddr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic [7:0] raddr_i,
	output logic      [7:0] rdata_o
);
	logic [7:0] mem [0:255];

	always_ff @(posedge clk_i)
	begin
		if (we_i)
			mem[waddr_i] <= wdata_i;
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rdata_o <= 8'h00;
		else
			rdata_o <= mem[raddr_i];
	end
endmodule : resp_buf
`default_nettype wire

// ==== test/dsi_host_model.sv ====
// Host side of the lane: sends short packets, hands the lane over, paces answers
`timescale 1ns/10ps
`default_nettype none
module dsi_host_model (
	input  wire logic       clk_i,
	input  wire logic       lane_oe_n_i,
	output logic            link_clk_o,
	output logic      [7:0] rx_byte_o,
	output logic            rx_act_o,
	output logic            bta_o,
	output logic            tx_ready_o
);
	integer seed = 15;
	initial
	begin
		link_clk_o = 1'b0;
		rx_byte_o  = 8'h00;
		rx_act_o   = 1'b0;
		bta_o      = 1'b0;
		tx_ready_o = 1'b0;
	end
	// Random ready, so answers are taken both promptly and slowly
	always @(posedge clk_i)
		tx_ready_o <= 1'($random(seed));
	function automatic logic [7:0] ecc(input logic [23:0] d);
		ecc = {2'b00, ^(d & 24'heffc00), ^(d & 24'hdf03f0), ^(d & 24'hb8e38e), ^(d & 24'h749a6d),
			^(d & 24'hf2555b), ^(d & 24'hf12cb7)};
	endfunction : ecc
	// Link clock stands still between frames; released data shows its inverse
	task automatic pkt(input logic [23:0] h, input logic [7:0] bad);
		logic [31:0] w;
		w = {ecc(h) ^ bad, h};
		// A clock edge between packets, so the burst flag is never driven twice at once
		@(posedge clk_i);
		rx_act_o <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			repeat (4) @(posedge clk_i);
			rx_byte_o  <= w[8*i +: 8];
			link_clk_o <= 1'b0;
			repeat (4) @(posedge clk_i);
			link_clk_o <= 1'b1;
		end
		repeat (4) @(posedge clk_i);
		link_clk_o <= 1'b0;
		repeat (8) @(posedge clk_i);
		rx_act_o  <= 1'b0;
		rx_byte_o <= ~w[31:24];
	endtask : pkt
	task automatic turn();
		bta_o <= 1'b1;
		repeat (8) @(posedge clk_i);
		while (lane_oe_n_i !== 1'b1)
			@(posedge clk_i);
		bta_o <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask : turn
endmodule : dsi_host_model
`default_nettype wire

// ==== test/dsi_resp_top_tb.sv ====
// Self-checking bench of the DSI response block
`timescale 1ns/10ps
`default_nettype none
module dsi_resp_top_tb;
	import dsi_resp_pkg::*;
	logic        clk_i, rstn_i, link_clk_i, rx_act_i, bta_i, tx_ready_i, tx_valid_o, lane_oe_n_o;
	logic        cmd_valid_o, rd_req_o, wr_i, rd_i;
	logic [7:0]  rx_byte_i, phy_err_i, tx_byte_o, cmd_d0_o, cmd_d1_o;
	logic [5:0]  cmd_dt_o;
	logic [3:0]  addr_i;
	logic [15:0] wdata_i, rdata_o;
	link_state_e link_state_o;
	logic [15:0] qt[$], qc[$];
	logic [7:0]  pay[5] = '{8'h89, 8'h23, 8'h12, 8'ha2, 8'he2};
	int          n_fail = 0, num_checks = 0, cyc = 0;
	bit          saw_ack;
	dsi_resp_top i_dsi_resp_top (.clk_i, .rstn_i, .link_clk_i, .rx_byte_i, .rx_act_i, .rx_hs_i(1'b0),
		.ulps_i(1'b0), .rar_i(1'b0), .bta_i, .phy_err_i, .tx_ready_i, .tx_byte_o, .tx_valid_o, .lane_oe_n_o,
		.link_state_o, .cmd_valid_o, .cmd_dt_o, .cmd_d0_o, .cmd_d1_o, .rd_req_o, .addr_i, .wdata_i, .wr_i,
		.rd_i, .rdata_o);
	dsi_host_model i_dsi_host_model (.clk_i, .lane_oe_n_i(lane_oe_n_o), .link_clk_o(link_clk_i),
		.rx_byte_o(rx_byte_i), .rx_act_o(rx_act_i), .bta_o(bta_i), .tx_ready_o(tx_ready_i));
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results
	task automatic chk(input logic [15:0] got, input logic [15:0] e);
		num_checks++;
		if (got !== e)
		begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, e);
		end
	endtask : chk
	// ==========================================
	// Observer: each answer byte or read-request pulse takes the oldest note, each command pulse the two oldest
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			results();
		end
		if (tx_valid_o && tx_ready_i)
			chk(tx_byte_o, qt.size() ? qt.pop_front() : 16'hxxxx);
		if (cmd_valid_o)
		begin
			chk({2'b00, cmd_dt_o, cmd_d0_o}, qc.size() ? qc.pop_front() : 16'hxxxx);
			chk({8'h00, cmd_d1_o}, qc.size() ? qc.pop_front() : 16'hxxxx);
		end
		if (rd_req_o)
			chk(16'hffff, qc.size() ? qc.pop_front() : 16'hxxxx);
		if (link_state_o === LS_ACK)
			saw_ack = 1'b1;
	end
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, e);
	endtask : rd
	task automatic exp(input logic [5:0] dt, input logic [7:0] d0, input logic [7:0] d1);
		qt.push_back({10'h000, dt});
		qt.push_back(d0);
		qt.push_back(d1);
		qt.push_back(i_dsi_host_model.ecc({d1, d0, 2'b00, dt}));
	endtask : exp
	// Hand the lane over, then every note must have been used
	task automatic done(input bit ack);
		saw_ack = 1'b0;
		i_dsi_host_model.turn();
		chk(saw_ack, ack);
		chk(qt.size() + qc.size(), 0);
		chk(lane_oe_n_o, 1'b1);
	endtask : done
	function automatic logic [15:0] crc(input int n);
		logic [15:0] c;
		c = 16'hffff;
		for (int i = 0; i < n; i++)
			for (int j = 0; j < 8; j++)
				c = (c[0] ^ pay[i][j]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
		crc = c;
	endfunction : crc
	// ==========================================
	// Main sequence
	initial
	begin
		rstn_i    = 1'b0;
		wr_i      = 1'b0;
		rd_i      = 1'b0;
		addr_i    = 4'h0;
		wdata_i   = 16'h0000;
		phy_err_i = 8'h00;
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		#1;
		chk(lane_oe_n_o, 1'b1);
		chk(link_state_o, LS_STOP);
		wr(4'h0, 16'h00a4);
		rd(4'h0, 16'h00a4);
		rd(4'h6, 16'h0000);
		rd(4'h3, 16'h0000);
		qc.push_back(16'h1536);
		qc.push_back(16'h0048);
		i_dsi_host_model.pkt(24'h483615, 8'h00);
		done(1'b1);
		phy_err_i <= 8'h11;
		i_dsi_host_model.pkt(24'h002915, 8'h00);
		phy_err_i <= 8'h00;
		i_dsi_host_model.pkt(24'h002815, 8'hc0);
		exp(6'h02, 8'h11, 8'h02);
		done(1'b0);
		rd(4'h3, 16'h0101);
		i_dsi_host_model.pkt(24'h000137, 8'h00);
		i_dsi_host_model.pkt(24'h000e06, 8'h01);
		exp(6'h21, 8'ha5, 8'h00);
		exp(6'h02, 8'h00, 8'h01);
		done(1'b0);
		i_dsi_host_model.pkt(24'h000506, 8'h00);
		exp(6'h21, 8'h02, 8'h00);
		done(1'b0);
		rd(4'h3, 16'h0000);
		for (int n = 2; n < 6; n += 3)
		begin
			wr(4'h1, 16'(n));
			for (int i = 0; i < n; i++)
				wr(4'h2, {8'h00, pay[i]});
			i_dsi_host_model.pkt({8'h00, 8'(n), 8'h37}, 8'h00);
			qc.push_back(16'hffff);
			i_dsi_host_model.pkt(24'h00da06, 8'h00);
			if (n == 2)
				exp(6'h22, pay[0], pay[1]);
			else
			begin
				exp(6'h1c, 8'h05, 8'h00);
				for (int i = 0; i < 5; i++)
					qt.push_back(pay[i]);
				qt.push_back(crc(5) & 16'h00ff);
				qt.push_back(crc(5) >> 8);
			end
			done(1'b0);
			rd(4'h5, {8'(n), 8'hda});
		end
		results();
	end
endmodule : dsi_resp_top_tb
`default_nettype wire
